// ---- design/mtp_defines.svh ----
// Constants for the machine timer and performance counter block.
// Assumes inclusion by bare name from the design module.
`ifndef MTP_DEFINES_SVH
`define MTP_DEFINES_SVH

// Memory-mapped word index (mmio_addr_i) of the timer halves
`define MTP_MMIO_WALL_LO   2'h0
`define MTP_MMIO_WALL_HI   2'h1
`define MTP_MMIO_CMP_LO    2'h2
`define MTP_MMIO_CMP_HI    2'h3

// Counter-register address groups: csr_addr_i[11:5]; index in csr_addr_i[4:0]
`define MTP_CSR_GRP_MLO    7'h00
`define MTP_CSR_GRP_MHI    7'h01
`define MTP_CSR_GRP_ULO    7'h02
`define MTP_CSR_GRP_UHI    7'h03
`define MTP_CSR_GRP_SEL    7'h04
`define MTP_CSR_ENABLE     12'h0A0
`define MTP_CSR_INHIBIT    12'h0A1

// Counter index and bit positions in enable and inhibit
`define MTP_IDX_CYCLE      5'h00
`define MTP_IDX_TIME       5'h01
`define MTP_IDX_RETIRE     5'h02
`define MTP_IDX_EVT_FIRST  5'h03

// Wall-time bit can never inhibit
`define MTP_INHIBIT_MASK   32'hFFFF_FFFD

// Privilege encodings on priv_i
`define MTP_PRIV_MACHINE   2'h3

// Event selection: values 1..MTP_NUM_EVENTS pick event_i bit value-1
`define MTP_NUM_EVENTS     5'h10

// Reset values; compare at all ones keeps the timer quiet after reset
`define MTP_CMP_RESET      64'hFFFF_FFFF_FFFF_FFFF
`define MTP_CNT_RESET      64'h0000_0000_0000_0000

`endif

// ---- design/mtp_pkg.sv ----
// Types for the machine timer and performance counter block.
// Assumes mtp_defines.svh on the include path.
package mtp_pkg;

    // Complete state of the block
    typedef struct packed {
        logic [63:0]        wall;
        logic [63:0]        cmp;
        logic [63:0]        cyc;
        logic [63:0]        ret;
        logic [28:0][63:0]  hpm;
        logic [28:0][4:0]   sel;
        logic [31:0]        en;
        logic [31:0]        inh;
        logic [2:0]         tick_sync;
        logic               tick_lvl;
        logic               pend;
        logic               mmio_ack;
        logic [31:0]        mmio_rdata;
        logic               csr_ack;
        logic               csr_illegal;
        logic [31:0]        csr_rdata;
    } mtp_state_t;

endpackage

// ---- design/mtp_timer_counters.sv ----
// Machine wall-time timer with compare, cycle, retire and 29 event counters.
// Assumes one 20 MHz clock, a wall-time tick pin and one-cycle access requests.
`timescale 1ns/10ps
`include "mtp_defines.svh"

////////////////////////////////////////////////////////////////////////////////
module mtp_timer_counters
    import mtp_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    input  wire logic        ce_i,
    input  wire logic        rtc_tick_i,
    input  wire logic        retire_i,
    input  wire logic [15:0] event_i,
    input  wire logic        global_int_en_i,
    input  wire logic        machine_timer_int_enable_i,
    input  wire logic        mmio_valid_i,
    input  wire logic        mmio_we_i,
    input  wire logic [1:0]  mmio_addr_i,
    input  wire logic [31:0] mmio_wdata_i,
    output logic             mmio_ack_o,
    output logic [31:0]      mmio_rdata_o,
    input  wire logic        csr_valid_i,
    input  wire logic        csr_we_i,
    input  wire logic [11:0] csr_addr_i,
    input  wire logic [1:0]  priv_i,
    input  wire logic [31:0] csr_wdata_i,
    output logic             csr_ack_o,
    output logic             csr_illegal_o,
    output logic [31:0]      csr_rdata_o,
    output logic             machine_timer_pending_o,
    output logic             timer_irq_o
);

    mtp_state_t q;
    mtp_state_t d;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Replace one 32-bit half of a 64-bit value
    function automatic logic [63:0] put_half(input logic [63:0] old,
                                             input logic [31:0] v,
                                             input logic        hi);
        put_half = hi ? {v, old[31:0]} : {old[63:32], v};
    endfunction

    // Pick one 32-bit half of a 64-bit value
    function automatic logic [31:0] get_half(input logic [63:0] v, input logic hi);
        get_half = hi ? v[63:32] : v[31:0];
    endfunction

    // Full 64-bit value of counter index n
    function automatic logic [63:0] cnt_value(input mtp_state_t s, input logic [4:0] n);
        if (n == `MTP_IDX_CYCLE) begin
            cnt_value = s.cyc;
        end else if (n == `MTP_IDX_TIME) begin
            cnt_value = s.wall;
        end else if (n == `MTP_IDX_RETIRE) begin
            cnt_value = s.ret;
        end else begin
            cnt_value = s.hpm[n - `MTP_IDX_EVT_FIRST];
        end
    endfunction

    // Selected event present this cycle; zero or out of range is no event
    function automatic logic evt_hit(input logic [4:0] sel, input logic [15:0] ev);
        logic [4:0] k;
        k = sel - 5'h01;
        evt_hit = (sel != 5'h00) && (sel <= `MTP_NUM_EVENTS) && ev[k[3:0]];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic
    logic       tick_rise;
    logic [4:0] idx;
    logic [6:0] grp;
    logic       is_m;

    always_comb begin
        d = q;
        d.mmio_ack    = 1'b0;
        d.csr_ack     = 1'b0;
        d.csr_illegal = 1'b0;
        idx  = csr_addr_i[4:0];
        grp  = csr_addr_i[11:5];
        is_m = (priv_i == `MTP_PRIV_MACHINE);

        // Tick pin filter: stage 0 feeds stage 1 only; 1 and 2 must agree
        d.tick_sync = {q.tick_sync[1:0], rtc_tick_i};
        if (q.tick_sync[1] == q.tick_sync[2]) begin
            d.tick_lvl = q.tick_sync[2];
        end
        tick_rise = (q.tick_sync[1] == q.tick_sync[2]) && q.tick_sync[2] && !q.tick_lvl;

        // Wall time ignores inhibit entirely
        if (tick_rise) begin
            d.wall = q.wall + 64'h0000_0000_0000_0001;
        end

        // Cycle and retire counting under inhibit
        if (!q.inh[`MTP_IDX_CYCLE]) begin
            d.cyc = q.cyc + 64'h0000_0000_0000_0001;
        end
        if (!q.inh[`MTP_IDX_RETIRE] && retire_i) begin
            d.ret = q.ret + 64'h0000_0000_0000_0001;
        end

        // Event counters; selector zero never counts
        for (int i = 0; i < 29; i++) begin
            if (!q.inh[i + 3] && evt_hit(q.sel[i], event_i)) begin
                d.hpm[i] = q.hpm[i] + 64'h0000_0000_0000_0001;
            end
        end

        // Compare every cycle; one-cycle lag after any write is accepted
        d.pend = (q.wall >= q.cmp);

        // Memory-mapped timer access; halves written independently
        if (mmio_valid_i) begin
            d.mmio_ack = 1'b1;
            if (mmio_we_i) begin
                if (mmio_addr_i == `MTP_MMIO_WALL_LO) begin
                    d.wall = put_half(q.wall, mmio_wdata_i, 1'b0);
                end else if (mmio_addr_i == `MTP_MMIO_WALL_HI) begin
                    d.wall = put_half(q.wall, mmio_wdata_i, 1'b1);
                end else if (mmio_addr_i == `MTP_MMIO_CMP_LO) begin
                    d.cmp = put_half(q.cmp, mmio_wdata_i, 1'b0);
                end else begin
                    d.cmp = put_half(q.cmp, mmio_wdata_i, 1'b1);
                end
            end
            if (mmio_addr_i[1]) begin
                d.mmio_rdata = get_half(q.cmp, mmio_addr_i[0]);
            end else begin
                d.mmio_rdata = get_half(q.wall, mmio_addr_i[0]);
            end
        end

        // Counter register access; writes win over the same cycle's increment
        if (csr_valid_i) begin
            d.csr_ack   = 1'b1;
            d.csr_rdata = 32'h0000_0000;
            if ((grp == `MTP_CSR_GRP_MLO) || (grp == `MTP_CSR_GRP_MHI)) begin
                if (!is_m) begin
                    d.csr_illegal = 1'b1;
                end else begin
                    d.csr_rdata = get_half(cnt_value(q, idx), grp[0]);
                    if (csr_we_i) begin
                        if (idx == `MTP_IDX_CYCLE) begin
                            d.cyc = put_half(q.cyc, csr_wdata_i, grp[0]);
                        end else if (idx == `MTP_IDX_RETIRE) begin
                            d.ret = put_half(q.ret, csr_wdata_i, grp[0]);
                        end else if (idx >= `MTP_IDX_EVT_FIRST) begin
                            d.hpm[idx - `MTP_IDX_EVT_FIRST] =
                                put_half(q.hpm[idx - `MTP_IDX_EVT_FIRST], csr_wdata_i,
                                         grp[0]);
                        end
                    end
                end
            end else if ((grp == `MTP_CSR_GRP_ULO) || (grp == `MTP_CSR_GRP_UHI)) begin
                // Read-only views; lower levels need their enable bit
                if (csr_we_i || (!is_m && !q.en[idx])) begin
                    d.csr_illegal = 1'b1;
                end else begin
                    d.csr_rdata = get_half(cnt_value(q, idx), grp[0]);
                end
            end else if (grp == `MTP_CSR_GRP_SEL) begin
                if (!is_m) begin
                    d.csr_illegal = 1'b1;
                end else if (idx >= `MTP_IDX_EVT_FIRST) begin
                    d.csr_rdata = {27'h000_0000, q.sel[idx - `MTP_IDX_EVT_FIRST]};
                    // Unsupported event codes fold to no event
                    if (csr_we_i) begin
                        d.sel[idx - `MTP_IDX_EVT_FIRST] =
                            ((csr_wdata_i <= 32'h0000_0010)) ? csr_wdata_i[4:0] : 5'h00;
                    end
                end
            end else if (csr_addr_i == `MTP_CSR_ENABLE) begin
                if (!is_m) begin
                    d.csr_illegal = 1'b1;
                end else begin
                    d.csr_rdata = q.en;
                    if (csr_we_i) begin
                        d.en = csr_wdata_i;
                    end
                end
            end else if (csr_addr_i == `MTP_CSR_INHIBIT) begin
                if (!is_m) begin
                    d.csr_illegal = 1'b1;
                end else begin
                    d.csr_rdata = q.inh;
                    if (csr_we_i) begin
                        d.inh = csr_wdata_i & `MTP_INHIBIT_MASK;
                    end
                end
            end else begin
                d.csr_illegal = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register; clock enable freezes everything
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            q     <= '0;
            q.cmp <= `MTP_CMP_RESET;
            q.cyc <= `MTP_CNT_RESET;
        end else if (ce_i) begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs; pending has no software write path
    assign machine_timer_pending_o = q.pend;
    assign timer_irq_o   = q.pend && global_int_en_i && machine_timer_int_enable_i;
    assign mmio_ack_o    = q.mmio_ack;
    assign mmio_rdata_o  = q.mmio_rdata;
    assign csr_ack_o     = q.csr_ack;
    assign csr_illegal_o = q.csr_illegal;
    assign csr_rdata_o   = q.csr_rdata;

endmodule

// ---- dv/mtp_props.sv ----
// Port checker for the timer and counter block.
// Assumes a bind onto mtp_timer_counters; one clock domain.
`timescale 1ns/10ps
module mtp_props (
    input wire logic        clk_i,
    input wire logic        resetn_i,
    input wire logic        ce_i,
    input wire logic        global_int_en_i,
    input wire logic        machine_timer_int_enable_i,
    input wire logic        mmio_valid_i,
    input wire logic        mmio_we_i,
    input wire logic        mmio_ack_o,
    input wire logic        csr_valid_i,
    input wire logic        csr_we_i,
    input wire logic [11:0] csr_addr_i,
    input wire logic [1:0]  priv_i,
    input wire logic        csr_ack_o,
    input wire logic        csr_illegal_o,
    input wire logic [31:0] csr_rdata_o,
    input wire logic        machine_timer_pending_o,
    input wire logic        timer_irq_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);
    ////////////////////////////////////////
    // Answers one cycle after each taken request; the memory-mapped ack never without one
    mmio_ack_a: assert property (mmio_valid_i && ce_i |=> mmio_ack_o)
        else $error("mmio ack missing");
    mmio_lone_a: assert property (mmio_ack_o |-> $past(mmio_valid_i && ce_i))
        else $error("mmio ack without request");
    csr_ack_a: assert property (csr_valid_i && ce_i |=> csr_ack_o)
        else $error("csr ack missing");
    // Refusals: flagged with the ack and carry no data
    ill_clean_a: assert property (csr_illegal_o |-> csr_ack_o && csr_rdata_o == 32'h0)
        else $error("illegal answer malformed");
    low_priv_a: assert property (
        csr_valid_i && ce_i && priv_i != 2'h3 && csr_addr_i[11:5] <= 7'h01 |=> csr_illegal_o)
        else $error("machine counter open to lower level");
    view_ro_a: assert property (
        csr_valid_i && ce_i && csr_we_i && csr_addr_i[11:6] == 6'h01 |=> csr_illegal_o)
        else $error("user view written");
    // Interrupt gate is pure logic, so any slip shows at once
    irq_gate_a: assert property (
        timer_irq_o == (machine_timer_pending_o && global_int_en_i && machine_timer_int_enable_i))
        else $error("timer irq gating wrong");
    // Pending drops only two cycles after a memory-mapped write
    pend_fall_a: assert property (
        $fell(machine_timer_pending_o) |-> $past(mmio_valid_i && mmio_we_i && ce_i, 2))
        else $error("pending fell without a write");
    cover property (csr_illegal_o);
    cover property ($rose(machine_timer_pending_o));
    cover property (timer_irq_o);
endmodule

bind mtp_timer_counters mtp_props mtp_props_inst (
    .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i), .global_int_en_i(global_int_en_i),
    .machine_timer_int_enable_i(machine_timer_int_enable_i), .mmio_valid_i(mmio_valid_i),
    .mmio_we_i(mmio_we_i), .mmio_ack_o(mmio_ack_o), .csr_valid_i(csr_valid_i),
    .csr_we_i(csr_we_i), .csr_addr_i(csr_addr_i), .priv_i(priv_i), .csr_ack_o(csr_ack_o),
    .csr_illegal_o(csr_illegal_o), .csr_rdata_o(csr_rdata_o),
    .machine_timer_pending_o(machine_timer_pending_o), .timer_irq_o(timer_irq_o));

// ---- dv/test_machine_timer_and_perf_counters.sv ----
// Self-checking bench for the timer and counter block.
// Assumes the design under design/ and the checker bound from mtp_props.sv.
`timescale 1ns/10ps
module test_machine_timer_and_perf_counters;
    logic        clk_i = 1'h0, resetn_i = 1'h0, tick_i = 1'h0, ret_i = 1'h0, gie = 1'h0;
    logic        machine_timer_int_enable = 1'h0, mv = 1'h0, cv = 1'h0, we = 1'h0, mack, cack, cill, pend;
    logic        ce = 1'h1, irq;
    logic [15:0] event_i = 16'h0000;
    logic [1:0]  priv = 2'h3;
    logic [11:0] ca = 12'h000;
    logic [31:0] wd = 32'h0, w, mrd, crd;
    logic [33:0] mq[$], cq[$], wok = 34'h0, bad = 34'h3_0000_0000;
    int          errors = 0, samples_checked = 0, cycles = 0, n = 0, r = 0;
    integer      seed = 32'hd377;

    // Clock enable dropped once mid-run to prove the freeze
    mtp_timer_counters mtp_timer_counters_inst (
        .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce), .rtc_tick_i(tick_i), .retire_i(ret_i),
        .event_i(event_i), .global_int_en_i(gie), .machine_timer_int_enable_i(machine_timer_int_enable),
        .mmio_valid_i(mv), .mmio_we_i(we), .mmio_addr_i(ca[1:0]), .mmio_wdata_i(wd),
        .mmio_ack_o(mack), .mmio_rdata_o(mrd), .csr_valid_i(cv), .csr_we_i(we),
        .csr_addr_i(ca), .priv_i(priv), .csr_wdata_i(wd), .csr_ack_o(cack),
        .csr_illegal_o(cill), .csr_rdata_o(crd), .machine_timer_pending_o(pend),
        .timer_irq_o(irq));
    ////////////////////////////////////////
    // 20 MHz clock, hang guard, free-running interrupt gate inputs
    always #25 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            test_done();
        end
    end
    always @(negedge clk_i) {gie, machine_timer_int_enable} <= 2'($random(seed));
    // Answers read at the edge after the ack, before this edge's updates land
    always @(posedge clk_i) begin
        if (mack === 1'h1)
            chk(mq.pop_front(), {1'h0, mrd});
        if (cack === 1'h1)
            chk(cq.pop_front(), {cill, crd});
    end
    // Note: {check data, illegal, data}
    task automatic chk(input logic [33:0] e, input logic [32:0] g);
        samples_checked++;
        if (g[32] !== e[32] || (e[33] && g[31:0] !== e[31:0])) begin
            errors++;
            $display("mismatch at %0t: got %h want %h", $time, g, e);
        end
    endtask
    function automatic logic [33:0] rv(input logic [31:0] v);
        return {2'h2, v};
    endfunction
    // One request; mw[1] picks the memory port, mw[0] a write
    task automatic acc(input logic [1:0] mw, input logic [1:0] p, input logic [11:0] a,
                       input logic [31:0] d, input logic [33:0] e);
        @(negedge clk_i);
        {we, priv, ca, wd} = {mw[0], p, a, d};
        if (mw[1]) begin
            mv = 1'h1;
            mq.push_back(e);
        end else begin
            cv = 1'h1;
            cq.push_back(e);
        end
        @(negedge clk_i);
        {mv, cv} = 2'h0;
        @(posedge clk_i);
    endtask
    // Tick pin held 4 cycles each way, longer than its filter needs
    task automatic tick(input int k);
        repeat (k) begin
            @(negedge clk_i);
            tick_i = 1'h1;
            repeat (4) @(negedge clk_i);
            tick_i = 1'h0;
            repeat (4) @(negedge clk_i);
        end
    endtask
    task automatic pchk(input logic e);
        repeat (2) @(negedge clk_i);
        chk({2'h2, 31'h0, e}, {1'h0, 31'h0, pend});
        chk({2'h2, 31'h0, e && gie && machine_timer_int_enable}, {1'h0, 31'h0, irq});
    endtask
    task automatic test_done();
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (16) @(negedge clk_i);
        resetn_i = 1'h1;
        // Timer: wall to zero, safe compare load to 5, edge at equality
        acc(2'h2, 2'h3, 12'h002, 32'h0, rv(32'hFFFF_FFFF));
        acc(2'h3, 2'h3, 12'h000, 32'h0, wok);
        acc(2'h3, 2'h3, 12'h001, 32'h0, wok);
        acc(2'h3, 2'h3, 12'h002, 32'hFFFF_FFFF, wok);
        acc(2'h3, 2'h3, 12'h003, 32'h0, wok);
        acc(2'h3, 2'h3, 12'h002, 32'h0000_0005, wok);
        acc(2'h2, 2'h3, 12'h003, 32'h0, rv(32'h0));
        tick(4);
        pchk(1'h0);
        tick(1);
        pchk(1'h1);
        acc(2'h2, 2'h3, 12'h000, 32'h0, rv(32'h0000_0005));
        acc(2'h3, 2'h3, 12'h002, 32'h0000_0006, wok);
        pchk(1'h0);
        // Lower-level access against the enable bits, refusals
        acc(2'h0, 2'h0, 12'h040, 32'h0, bad);
        acc(2'h1, 2'h3, 12'h0A0, 32'h0000_0007, wok);
        acc(2'h0, 2'h0, 12'h041, 32'h0, rv(32'h0000_0005));
        acc(2'h1, 2'h0, 12'h040, 32'h0, bad);
        acc(2'h0, 2'h0, 12'h000, 32'h0, bad);
        acc(2'h0, 2'h3, 12'h0FF, 32'h0, bad);
        // Cycle counter runs, then stops under inhibit; wall bit never sticks
        w = $random(seed);
        acc(2'h1, 2'h3, 12'h000, w, wok);
        acc(2'h0, 2'h3, 12'h000, 32'h0, rv(w + 32'h1));
        acc(2'h1, 2'h3, 12'h0A1, 32'hFFFF_FFFF, wok);
        acc(2'h0, 2'h3, 12'h0A1, 32'h0, rv(32'hFFFF_FFFD));
        acc(2'h1, 2'h3, 12'h000, w, wok);
        acc(2'h0, 2'h0, 12'h040, 32'h0, rv(w));
        // Events: counter 3 counts line 4, 4 has an out-of-range select, 5 inhibited
        acc(2'h1, 2'h3, 12'h0A1, 32'h0000_0020, wok);
        acc(2'h1, 2'h3, 12'h083, 32'h0000_0005, wok);
        acc(2'h1, 2'h3, 12'h084, 32'h0000_0011, wok);
        acc(2'h1, 2'h3, 12'h085, 32'h0000_0005, wok);
        for (int i = 2; i < 6; i++)
            acc(2'h1, 2'h3, 12'(i), 32'h0, wok);
        repeat (60) begin
            @(negedge clk_i);
            {ret_i, event_i} = 17'($random(seed));
            r += ret_i;
            n += event_i[4];
        end
        @(negedge clk_i);
        {ret_i, event_i} = 17'h0_0000;
        acc(2'h0, 2'h3, 12'h002, 32'h0, rv(32'(r)));
        acc(2'h0, 2'h3, 12'h003, 32'h0, rv(32'(n)));
        acc(2'h0, 2'h3, 12'h004, 32'h0, rv(32'h0));
        acc(2'h0, 2'h3, 12'h005, 32'h0, rv(32'h0));
        // Upper halves; a high write leaves the low half alone
        acc(2'h1, 2'h3, 12'h022, w, wok);
        acc(2'h0, 2'h3, 12'h062, 32'h0, rv(w));
        acc(2'h0, 2'h3, 12'h002, 32'h0, rv(32'(r)));
        // Clock enable low for five edges: cycle count stands still
        acc(2'h1, 2'h3, 12'h000, w, wok);
        @(negedge clk_i);
        ce = 1'h0;
        repeat (5) @(negedge clk_i);
        ce = 1'h1;
        acc(2'h0, 2'h3, 12'h000, 32'h0, rv(w + 32'h2));
        // Carry into the upper wall half
        acc(2'h3, 2'h3, 12'h000, 32'hFFFF_FFFF, wok);
        tick(1);
        acc(2'h2, 2'h3, 12'h001, 32'h0, rv(32'h0000_0001));
        acc(2'h2, 2'h3, 12'h000, 32'h0, rv(32'h0));
        repeat (3) @(negedge clk_i);
        test_done();
    end
endmodule
